// ### ccrc_pkg.sv
// Constants for the converter configuration and run-control register bank
package ccrc_pkg;
  localparam int          NCH          = 100;
  localparam logic [15:0] A_CNT        = 16'h0132;
  localparam logic [15:0] A_UNIT       = 16'h0133;
  localparam logic [15:0] A_RUN        = 16'h0134;
  localparam logic [15:0] A_HOLD       = 16'h0198;
  localparam logic [15:0] A_NET        = 16'h8000;
  localparam logic [15:0] A_TXT        = 16'h8001;
  localparam logic [15:0] A_PORT       = 16'h8002;
  localparam logic [15:0] A_HPROT      = 16'h8004;
  localparam logic [15:0] A_BAUD       = 16'h8005;
  localparam logic [15:0] A_FRAME      = 16'h8006;
  localparam logic [15:0] A_IVL        = 16'h8007;
  localparam logic [15:0] CH_SPAN      = 16'h0064;
  localparam logic [15:0] NET_MODBUS   = 16'h0000;
  localparam logic [15:0] NET_PLC      = 16'h0003;
  localparam logic [15:0] TXT_RST      = 16'h0001;
  localparam logic [15:0] PORT_RST     = 16'h01f6;
  localparam logic        HP_OWN       = 1'b0;
  localparam logic        HP_MODBUS    = 1'b1;
  localparam logic [1:0]  BAUD_4800    = 2'h0;
  localparam logic [1:0]  BAUD_9600    = 2'h1;
  localparam logic [1:0]  BAUD_19200   = 2'h2;
  localparam logic [1:0]  BAUD_38400   = 2'h3;
  localparam logic [15:0] BAUD_MAX     = 16'h0003;
  localparam logic [15:0] RATE_4800    = 16'h12c0;
  localparam logic [15:0] RATE_9600    = 16'h2580;
  localparam logic [15:0] RATE_19200   = 16'h4b00;
  localparam logic [15:0] RATE_38400   = 16'h9600;
  localparam logic [2:0]  FRAME_RST    = 3'h0;
  localparam logic [15:0] FRAME_MAX    = 16'h0005;
  localparam logic [15:0] FRAME_7BIT   = 16'h0003;
  localparam logic [3:0]  BITS_8       = 4'h8;
  localparam logic [3:0]  BITS_7       = 4'h7;
  localparam logic [1:0]  PAR_NONE     = 2'h0;
  localparam logic [1:0]  PAR_EVEN     = 2'h1;
  localparam logic [1:0]  PAR_ODD      = 2'h2;
  localparam logic [15:0] IVL_MAX      = 16'h00fa;
  localparam logic [7:0]  IVL_RST      = 8'h0a;
endpackage

// ### ccrc_chan_if.sv
// Per-channel run and hold signals between the bank front end and storage
`timescale 1ns/1ps
interface ccrc_chan_if;
  logic                     wr_run;
  logic                     wr_hold;
  logic [6:0]               idx;
  logic                     wbit;
  logic                     reboot;
  logic [ccrc_pkg::NCH-1:0] run;
  logic [ccrc_pkg::NCH-1:0] hold;
  modport ctrl (output wr_run, output wr_hold, output idx, output wbit, output reboot,
                input run, input hold);
  modport bank (input wr_run, input wr_hold, input idx, input wbit, input reboot,
                output run, output hold);
endinterface

// ### ccrc_chan_bank.sv
// Per-module run/stop and hold storage
`timescale 1ns/1ps
module ccrc_chan_bank (
  input wire logic clock,
  input wire logic resetn,
  ccrc_chan_if.bank ch
);
  logic [ccrc_pkg::NCH-1:0] run_q;
  logic [ccrc_pkg::NCH-1:0] hold_q;

  genvar i;
  generate
    for (i = 0; i < ccrc_pkg::NCH; i++) begin : g_ch
      wire sel = (ch.idx == 7'(i));
      always_ff @(posedge clock) begin
        if (!resetn) begin
          run_q[i] <= 1'b0;
        end else if (ch.wr_run && sel) begin
          run_q[i] <= ch.wbit;
        end else if (ch.reboot && !hold_q[i]) begin
          run_q[i] <= 1'b0;
        end
      end
      always_ff @(posedge clock) begin
        if (!resetn) begin
          hold_q[i] <= 1'b1;
        end else if (ch.wr_hold && sel) begin
          hold_q[i] <= ch.wbit;
        end
      end
    end
  endgenerate

  assign ch.run  = run_q;
  assign ch.hold = hold_q;

  a_run_write: assert property (@(posedge clock) disable iff (!resetn)
    ch.wr_run |=> run_q[$past(ch.idx)] == $past(ch.wbit))
    else $error("module run word not written");
  a_reboot_stop: assert property (@(posedge clock) disable iff (!resetn)
    ch.reboot && !hold_q[0] && !(ch.wr_run && ch.idx == 7'h00) |=> !run_q[0])
    else $error("non-held channel kept running after reboot");
endmodule

// ### ccrc_top.sv
// Configuration and run-control register bank of the communication converter
`timescale 1ns/1ps
module ccrc_top (
  input  wire logic         clock,
  input  wire logic         resetn,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  input  wire logic [15:0]  reg_addr,
  input  wire logic [15:0]  reg_wdata,
  output logic      [15:0]  reg_rdata,
  output logic              reg_ack,
  output logic              reg_err,
  input  wire logic [4:0]   module_count,
  input  wire logic         reboot,
  output logic              unit_run,
  output logic      [99:0]  module_run,
  output logic              set_lock_clear,
  output logic      [1:0]   net_protocol_active,
  output logic      [15:0]  tcp_port_active,
  output logic              text_or_binary,
  output logic              host_protocol,
  output logic      [15:0]  host_bit_rate,
  output logic      [3:0]   host_data_bits,
  output logic      [1:0]   host_parity,
  output logic      [7:0]   host_interval_ms
);
  ccrc_chan_if ch ();

  logic        unit_q;
  logic [1:0]  net_pend_q;
  logic [1:0]  net_act_q;
  logic [15:0] port_pend_q;
  logic [15:0] port_act_q;
  logic        txt_q;
  logic        hprot_q;
  logic [1:0]  baud_q;
  logic [2:0]  frame_q;
  logic [7:0]  ivl_q;
  logic [15:0] rdata_q;
  logic        ack_q;
  logic        err_q;
  logic        lock_clr_q;
  logic [15:0] rate_q;
  logic [15:0] rate_d;
  logic [3:0]  bits_q;
  logic [1:0]  par_q;

  // Address decode
  wire [15:0] run_off  = reg_addr - ccrc_pkg::A_RUN;
  wire [15:0] hold_off = reg_addr - ccrc_pkg::A_HOLD;
  wire        hit_cnt  = reg_addr == ccrc_pkg::A_CNT;
  wire        hit_unit = reg_addr == ccrc_pkg::A_UNIT;
  wire        hit_run  = (reg_addr >= ccrc_pkg::A_RUN) && (run_off < ccrc_pkg::CH_SPAN);
  wire        hit_hold = (reg_addr >= ccrc_pkg::A_HOLD) && (hold_off < ccrc_pkg::CH_SPAN);
  wire        hit_net  = reg_addr == ccrc_pkg::A_NET;
  wire        hit_txt  = reg_addr == ccrc_pkg::A_TXT;
  wire        hit_port = reg_addr == ccrc_pkg::A_PORT;
  wire        hit_hp   = reg_addr == ccrc_pkg::A_HPROT;
  wire        hit_baud = reg_addr == ccrc_pkg::A_BAUD;
  wire        hit_frm  = reg_addr == ccrc_pkg::A_FRAME;
  wire        hit_ivl  = reg_addr == ccrc_pkg::A_IVL;
  wire        hit_any  = hit_cnt | hit_unit | hit_run | hit_hold | hit_net | hit_txt
                       | hit_port | hit_hp | hit_baud | hit_frm | hit_ivl;
  wire        wbool    = reg_wdata[15:1] == 15'h0000;
  wire        w7bit    = reg_wdata >= ccrc_pkg::FRAME_7BIT;
  wire        f7bit    = 16'(frame_q) >= ccrc_pkg::FRAME_7BIT;

  // Value checks; out-of-range data is refused, not clipped
  wire ok_unit = hit_unit & wbool;
  wire ok_run  = hit_run & wbool;
  wire ok_hold = hit_hold & wbool;
  // only the two protocol codes are legal
  wire ok_net  = hit_net & ((reg_wdata == ccrc_pkg::NET_MODBUS)
                          | (reg_wdata == ccrc_pkg::NET_PLC));
  wire ok_txt  = hit_txt & wbool;
  wire ok_port = hit_port;
  // Modbus refused while a 7-bit frame is set
  wire ok_hp   = hit_hp & wbool & !((reg_wdata[0] == ccrc_pkg::HP_MODBUS) & f7bit);
  wire ok_baud = hit_baud & (reg_wdata <= ccrc_pkg::BAUD_MAX);
  wire ok_frm  = hit_frm & (reg_wdata <= ccrc_pkg::FRAME_MAX)
               & !((hprot_q == ccrc_pkg::HP_MODBUS) & w7bit);
  wire ok_ivl  = hit_ivl & (reg_wdata <= ccrc_pkg::IVL_MAX);
  // count monitor and unused words take no write
  wire wr_ok   = ok_unit | ok_run | ok_hold | ok_net | ok_txt | ok_port
               | ok_hp | ok_baud | ok_frm | ok_ivl;
  wire do_wr   = reg_wr & wr_ok;
  wire do_rd   = reg_rd & !reg_wr;

  assign ch.wr_run  = reg_wr & ok_run;
  assign ch.wr_hold = reg_wr & ok_hold;
  assign ch.idx     = hit_hold ? hold_off[6:0] : run_off[6:0];
  assign ch.wbit    = reg_wdata[0];
  assign ch.reboot  = reboot;

  ccrc_chan_bank u_bank (
    .clock  (clock),
    .resetn (resetn),
    .ch     (ch)
  );

  // Read mux
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    if (hit_cnt) begin
      // five-bit count keeps the value within 0..31
      rd_mux = {11'h000, module_count};
    end else if (hit_unit) begin
      rd_mux = {15'h0000, unit_q};
    end else if (hit_run) begin
      rd_mux = {15'h0000, ch.run[ch.idx]};
    end else if (hit_hold) begin
      rd_mux = {15'h0000, ch.hold[ch.idx]};
    end else if (hit_net) begin
      rd_mux = {14'h0000, net_pend_q};
    end else if (hit_txt) begin
      rd_mux = {15'h0000, txt_q};
    end else if (hit_port) begin
      rd_mux = port_pend_q;
    end else if (hit_hp) begin
      rd_mux = {15'h0000, hprot_q};
    end else if (hit_baud) begin
      rd_mux = {14'h0000, baud_q};
    end else if (hit_frm) begin
      rd_mux = {13'h0000, frame_q};
    end else if (hit_ivl) begin
      rd_mux = {8'h00, ivl_q};
    end
  end

  always_comb begin
    unique case (baud_q)
      ccrc_pkg::BAUD_4800:  rate_d = ccrc_pkg::RATE_4800;
      ccrc_pkg::BAUD_9600:  rate_d = ccrc_pkg::RATE_9600;
      ccrc_pkg::BAUD_19200: rate_d = ccrc_pkg::RATE_19200;
      ccrc_pkg::BAUD_38400: rate_d = ccrc_pkg::RATE_38400;
    endcase
  end

  // codes 0..2 eight bits, 3..5 seven; parity cycles
  wire [2:0] par_idx = f7bit ? frame_q - ccrc_pkg::FRAME_7BIT[2:0] : frame_q;
  wire [1:0] par_d   = (par_idx == 3'h0) ? ccrc_pkg::PAR_NONE
                     : (par_idx == 3'h1) ? ccrc_pkg::PAR_EVEN : ccrc_pkg::PAR_ODD;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      rate_q <= ccrc_pkg::RATE_19200;
      bits_q <= ccrc_pkg::BITS_8;
      par_q  <= ccrc_pkg::PAR_NONE;
    end else begin
      rate_q <= rate_d;
      bits_q <= f7bit ? ccrc_pkg::BITS_7 : ccrc_pkg::BITS_8;
      par_q  <= par_d;
    end
  end

  // Bus answer, one cycle after the request
  always_ff @(posedge clock) begin
    if (!resetn) begin
      rdata_q <= 16'h0000;
      ack_q   <= 1'b0;
      err_q   <= 1'b0;
    end else begin
      rdata_q <= do_rd ? rd_mux : rdata_q;
      ack_q   <= do_wr | (do_rd & hit_any);
      err_q   <= (reg_wr & !wr_ok) | (do_rd & !hit_any);
    end
  end

  // unit run word, stopped after reset
  always_ff @(posedge clock) begin
    if (!resetn) begin
      unit_q <= 1'b0;
    end else if (reg_wr && ok_unit) begin
      unit_q <= reg_wdata[0];
    end
  end

  // pulse on a run-to-stop change only
  always_ff @(posedge clock) begin
    if (!resetn) begin
      lock_clr_q <= 1'b0;
    end else begin
      lock_clr_q <= reg_wr & ok_unit & unit_q & !reg_wdata[0];
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      net_pend_q  <= ccrc_pkg::NET_MODBUS[1:0];
      port_pend_q <= ccrc_pkg::PORT_RST;
      txt_q       <= ccrc_pkg::TXT_RST[0];
      hprot_q     <= ccrc_pkg::HP_OWN;
      baud_q      <= ccrc_pkg::BAUD_19200;
      frame_q     <= ccrc_pkg::FRAME_RST;
      ivl_q       <= ccrc_pkg::IVL_RST;
    end else if (reg_wr) begin
      net_pend_q  <= ok_net ? reg_wdata[1:0] : net_pend_q;
      port_pend_q <= ok_port ? reg_wdata : port_pend_q;
      txt_q       <= ok_txt ? reg_wdata[0] : txt_q;
      hprot_q     <= ok_hp ? reg_wdata[0] : hprot_q;
      baud_q      <= ok_baud ? reg_wdata[1:0] : baud_q;
      frame_q     <= ok_frm ? reg_wdata[2:0] : frame_q;
      ivl_q       <= ok_ivl ? reg_wdata[7:0] : ivl_q;
    end
  end

  // pending network settings take effect at reboot
  always_ff @(posedge clock) begin
    if (!resetn) begin
      net_act_q  <= ccrc_pkg::NET_MODBUS[1:0];
      port_act_q <= ccrc_pkg::PORT_RST;
    end else if (reboot) begin
      net_act_q  <= net_pend_q;
      port_act_q <= port_pend_q;
    end
  end

  assign reg_rdata           = rdata_q;
  assign reg_ack             = ack_q;
  assign reg_err             = err_q;
  assign unit_run            = unit_q;
  assign module_run          = ch.run;
  assign set_lock_clear      = lock_clr_q;
  assign net_protocol_active = net_act_q;
  assign tcp_port_active     = port_act_q;
  assign text_or_binary      = txt_q;
  assign host_protocol       = hprot_q;
  assign host_bit_rate       = rate_q;
  assign host_data_bits      = bits_q;
  assign host_parity         = par_q;
  assign host_interval_ms    = ivl_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence s_stop_write;
    reg_wr && ok_unit && unit_q && !reg_wdata[0];
  endsequence
  sequence s_one_pulse;
    set_lock_clear ##1 !set_lock_clear;
  endsequence

  a_count_read: assert property (do_rd && hit_cnt |=>
    reg_ack && reg_rdata == {11'h000, $past(module_count)})
    else $error("count monitor read wrong");
  a_unit_change: assert property (!$stable(unit_run) |-> $past(reg_wr && ok_unit))
    else $error("unit run changed without write");
  a_lock_clear: assert property (s_stop_write |=> s_one_pulse)
    else $error("set lock clear pulse missing");
  a_net_legal: assert property (net_pend_q == 2'h0 || net_pend_q == 2'h3)
    else $error("illegal network protocol held");
  a_net_deferred: assert property (!$stable(net_protocol_active)
    || !$stable(tcp_port_active) |-> $past(reboot))
    else $error("network setting applied without reboot");
  a_baud_map: assert property (baud_q == ccrc_pkg::BAUD_4800 ##1
    baud_q == ccrc_pkg::BAUD_4800 |-> host_bit_rate == ccrc_pkg::RATE_4800)
    else $error("bit rate does not follow speed code");
  a_frame_bits: assert property ($stable(frame_q) && f7bit |=>
    host_data_bits == ccrc_pkg::BITS_7)
    else $error("seven-bit frame not decoded");
  a_ivl_range: assert property (16'(ivl_q) <= ccrc_pkg::IVL_MAX)
    else $error("interval above limit");
  a_hprot_frame: assert property (!(hprot_q == ccrc_pkg::HP_MODBUS && f7bit))
    else $error("seven-bit frame under Modbus");
  a_ro_refused: assert property (reg_wr && (hit_cnt || !hit_any) |=>
    reg_err && !reg_ack)
    else $error("write to read-only or unused word accepted");
endmodule

// ### ccrc_host.sv
// Host model that issues word requests on the register request port
`timescale 1ns/1ps
module ccrc_host (
  input  wire logic        clock,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [15:0] reg_addr,
  output logic      [15:0] reg_wdata,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_ack,
  input  wire logic        reg_err
);
  // Time of the last release, so a back-to-back call never re-raises in that step
  realtime last_rel = -1.0;

  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 16'h0000;
    reg_wdata = 16'h0000;
  end

  // Enter just after a rising edge; returns just after the answer edge
  task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
                      output logic ack, output logic err, output logic [15:0] q);
    if ($realtime == last_rel) begin
      @(posedge clock);
      #1;
    end
    reg_wr    = w;
    reg_rd    = ~w;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge clock);
    #1;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    // Inverted leftovers so a stale address never looks like a request
    reg_addr  = ~a;
    reg_wdata = ~d;
    ack       = reg_ack;
    err       = reg_err;
    q         = reg_rdata;
    last_rel  = $realtime;
  endtask
endmodule

// ### tb.sv
// Self-checking testbench of the configuration and run-control bank
`timescale 1ns/1ps
module tb;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic        reboot = 1'b0;
  logic [4:0]  module_count = 5'h00;
  logic        reg_wr, reg_rd, reg_ack, reg_err;
  logic [15:0] reg_addr, reg_wdata, reg_rdata;
  logic        unit_run, set_lock_clear, text_or_binary, host_protocol;
  logic [99:0] module_run;
  logic [1:0]  net_protocol_active, host_parity;
  logic [15:0] tcp_port_active, host_bit_rate;
  logic [3:0]  host_data_bits;
  logic [7:0]  host_interval_ms;
  int          failures = 0;
  int          checks_done = 0;

  always #25 clock = ~clock;

  ccrc_host host (.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_err(reg_err));

  ccrc_top dut (.clock(clock), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .reg_err(reg_err), .module_count(module_count), .reboot(reboot), .unit_run(unit_run),
    .module_run(module_run), .set_lock_clear(set_lock_clear),
    .net_protocol_active(net_protocol_active), .tcp_port_active(tcp_port_active),
    .text_or_binary(text_or_binary), .host_protocol(host_protocol),
    .host_bit_rate(host_bit_rate), .host_data_bits(host_data_bits),
    .host_parity(host_parity), .host_interval_ms(host_interval_ms));

  task automatic summarize();
    $display("failures=%0d checks_done=%0d", failures, checks_done);
    if (failures == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic step();
    @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic bad = 1'b0);
    logic        ack, err;
    logic [15:0] q;
    host.xfer(1'b1, a, d, ack, err, q);
    check("write ack", {15'h0, ~bad}, {15'h0, ack});
    check("write err", {15'h0, bad}, {15'h0, err});
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] exp, input logic bad = 1'b0);
    logic        ack, err;
    logic [15:0] q;
    host.xfer(1'b0, a, 16'h0000, ack, err, q);
    check("read ack", {15'h0, ~bad}, {15'h0, ack});
    check("read err", {15'h0, bad}, {15'h0, err});
    check("read data", exp, q);
  endtask

  task automatic pulse_reboot();
    reboot = 1'b1;
    step();
    reboot = 1'b0;
  endtask

  task automatic t_reset();
    rd(ccrc_pkg::A_UNIT, 16'h0000);
    rd(ccrc_pkg::A_RUN + 16'h0063, 16'h0000);
    rd(ccrc_pkg::A_HOLD + 16'h0063, 16'h0001);
    rd(ccrc_pkg::A_NET, 16'h0000);
    rd(ccrc_pkg::A_TXT, 16'h0001);
    rd(ccrc_pkg::A_PORT, 16'h01f6);
    rd(ccrc_pkg::A_HPROT, 16'h0000);
    rd(ccrc_pkg::A_BAUD, 16'h0002);
    rd(ccrc_pkg::A_FRAME, 16'h0000);
    rd(ccrc_pkg::A_IVL, 16'h000a);
    check("rate", 16'h4b00, host_bit_rate);
    check("bits", 16'h0008, {12'h0, host_data_bits});
    check("ivl", 16'h000a, {8'h0, host_interval_ms});
  endtask

  task automatic t_count();
    module_count = 5'h1f;
    rd(ccrc_pkg::A_CNT, 16'h001f);
    module_count = 5'h00;
    rd(ccrc_pkg::A_CNT, 16'h0000);
    wr(ccrc_pkg::A_CNT, 16'h0001, 1'b1);
    rd(16'h8003, 16'h0000, 1'b1);
    rd(16'h8008, 16'h0000, 1'b1);
    wr(16'h0131, 16'h0001, 1'b1);
    wr(ccrc_pkg::A_HOLD + 16'h0064, 16'h0000, 1'b1);
    wr(ccrc_pkg::A_TXT, 16'h0002, 1'b1);
    check("txt", 16'h0001, {15'h0, text_or_binary});
    wr(ccrc_pkg::A_TXT, 16'h0000);
    check("txt", 16'h0000, {15'h0, text_or_binary});
  endtask

  task automatic t_unit();
    wr(ccrc_pkg::A_UNIT, 16'h0001);
    check("run", 16'h0001, {15'h0, unit_run});
    check("clear", 16'h0000, {15'h0, set_lock_clear});
    wr(ccrc_pkg::A_UNIT, 16'h0000);
    check("run", 16'h0000, {15'h0, unit_run});
    check("clear", 16'h0001, {15'h0, set_lock_clear});
    step();
    check("clear", 16'h0000, {15'h0, set_lock_clear});
    wr(ccrc_pkg::A_UNIT, 16'h0002, 1'b1);
    check("run", 16'h0000, {15'h0, unit_run});
  endtask

  task automatic t_chan_net();
    wr(ccrc_pkg::A_UNIT, 16'h0001);
    wr(ccrc_pkg::A_RUN, 16'h0001);
    wr(ccrc_pkg::A_RUN + 16'h0063, 16'h0001);
    check("ch1", 16'h0001, {15'h0, module_run[0]});
    check("ch100", 16'h0001, {15'h0, module_run[99]});
    wr(ccrc_pkg::A_HOLD, 16'h0000);
    wr(ccrc_pkg::A_NET, 16'h0001, 1'b1);
    wr(ccrc_pkg::A_NET, 16'h0003);
    wr(ccrc_pkg::A_PORT, 16'h1000);
    rd(ccrc_pkg::A_NET, 16'h0003);
    check("net", 16'h0000, {14'h0, net_protocol_active});
    check("port", 16'h01f6, tcp_port_active);
    pulse_reboot();
    check("net", 16'h0003, {14'h0, net_protocol_active});
    check("port", 16'h1000, tcp_port_active);
    check("ch1", 16'h0000, {15'h0, module_run[0]});
    check("ch100", 16'h0001, {15'h0, module_run[99]});
    check("run", 16'h0001, {15'h0, unit_run});
  endtask

  task automatic t_serial();
    logic [15:0] rates [4];
    rates = '{16'h12c0, 16'h2580, 16'h4b00, 16'h9600};
    for (int i = 0; i < 4; i++) begin
      wr(ccrc_pkg::A_BAUD, 16'(i));
      step();
      check("rate", rates[i], host_bit_rate);
    end
    wr(ccrc_pkg::A_BAUD, 16'h0004, 1'b1);
    for (int f = 0; f < 6; f++) begin
      wr(ccrc_pkg::A_FRAME, 16'(f));
      step();
      check("bits", (f < 3) ? 16'h0008 : 16'h0007, {12'h0, host_data_bits});
      check("parity", 16'(f % 3), {14'h0, host_parity});
    end
    wr(ccrc_pkg::A_FRAME, 16'h0006, 1'b1);
    wr(ccrc_pkg::A_HPROT, 16'h0001, 1'b1);
    wr(ccrc_pkg::A_FRAME, 16'h0000);
    wr(ccrc_pkg::A_HPROT, 16'h0001);
    check("hprot", 16'h0001, {15'h0, host_protocol});
    wr(ccrc_pkg::A_FRAME, 16'h0003, 1'b1);
    wr(ccrc_pkg::A_IVL, 16'h00fa);
    wr(ccrc_pkg::A_IVL, 16'h00fb, 1'b1);
    check("ivl", 16'h00fa, {8'h0, host_interval_ms});
    wr(ccrc_pkg::A_IVL, 16'h0000);
    check("ivl", 16'h0000, {8'h0, host_interval_ms});
  endtask

  initial begin
    repeat (5) @(posedge clock);
    #1;
    resetn = 1'b1;
    t_reset();
    t_count();
    t_unit();
    t_chan_net();
    t_serial();
    summarize();
  end

  // Whole sequence is about a hundred cycles; this leaves ample margin
  initial begin
    #(2000 * 50);
    failures++;
    summarize();
  end
endmodule
